// ### hw/tsi_pkg.sv
// Constants for the idle-code and interrupt status register slice
`default_nettype none

package tsi_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_IDLE_ONE   = 8'h03;
    localparam logic [7:0] OFS_IDLE_TWO   = 8'h04;
    localparam logic [7:0] OFS_IDLE_THREE = 8'h05;
    localparam logic [7:0] OFS_MASTER_EN  = 8'h06;
    localparam logic [7:0] OFS_STATUS     = 8'h07;
    localparam logic [7:0] OFS_EVENT_MASK = 8'h08;

    // ------------------------------------------------------------
    // Status, mask and master enable bit positions
    // ------------------------------------------------------------
    localparam int BIT_FRAME_SYNC_ERR = 6;
    localparam int BIT_PATTERN_FOUND  = 5;
    localparam int BIT_PATTERN_ERR    = 3;
    localparam int BIT_SELFTEST_DONE  = 1;
    localparam int BIT_INSERT_DONE    = 0;
    localparam int BIT_MASTER_EN      = 0;

    // ------------------------------------------------------------
    // Reset values and read masks
    // ------------------------------------------------------------
    localparam logic [7:0] RST_IDLE_CODE  = 8'h00;
    localparam logic [7:0] RST_EVENT_MASK = 8'h7F;
    localparam logic [7:0] MASK_RSVD_ONES = 8'h14;
    localparam logic [7:0] MASK_WRITABLE  = 8'h6B;
    localparam logic [7:0] STATUS_USED    = 8'h6B;

    // ------------------------------------------------------------
    // Pattern checker and slot modes
    // ------------------------------------------------------------
    localparam int LOCK_SLOTS = 32;

    typedef enum logic [1:0] {
        TSI_MODE_PASS  = 2'b00,
        TSI_MODE_IDLE1 = 2'b01,
        TSI_MODE_IDLE2 = 2'b10,
        TSI_MODE_IDLE3 = 2'b11
    } tsi_slot_mode_t;

endpackage : tsi_pkg

`default_nettype wire

// ### hw/tsi_pat_lock.sv
// Test-pattern checker lock tracker: found state and error pulses
`default_nettype none

module tsi_pat_lock #(
    parameter int LOCK_SLOTS = tsi_pkg::LOCK_SLOTS
) (
    input  wire logic core_clk,
    input  wire logic rst_b,
    input  wire logic chk_run,
    input  wire logic slot_valid,
    input  wire logic slot_error,
    output var  logic found,
    output var  logic error_pulse
);

    localparam int CW = $clog2(LOCK_SLOTS + 1);
    localparam logic [CW-1:0] LAST = CW'(LOCK_SLOTS - 1);

    logic [CW-1:0] clean_cnt;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire good_slot  = chk_run & slot_valid & ~slot_error;
    wire bad_slot   = chk_run & slot_valid & slot_error;
    wire reach_lock = good_slot & ~found & (clean_cnt == LAST);

    // Count clean slots across frames until locked
    always_ff @(posedge core_clk) begin
        if (!rst_b || !chk_run || bad_slot) begin
            clean_cnt <= '0;
        end else if (good_slot && !found) begin
            clean_cnt <= clean_cnt + CW'(1);
        end
    end

    // Found state and per-error pulse once locked
    always_ff @(posedge core_clk) begin
        if (!rst_b || !chk_run) begin
            found       <= 1'b0;
            error_pulse <= 1'b0;
        end else begin
            found       <= found | reach_lock;
            error_pulse <= bad_slot & found;
        end
    end

    // Lock needs the full run of clean slots
    lock_count_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        $rose(found) |-> $past(clean_cnt) == LAST)
        else $error("pattern found before enough clean slots");

    // Errors only flagged after lock
    err_after_lock_a: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        error_pulse |-> $past(found) && $past(bad_slot))
        else $error("pattern error flagged without lock");

endmodule : tsi_pat_lock

`default_nettype wire

// ### hw/tsi_irq_status.sv
// Idle-code registers, interrupt enable, mask and status with irq output
`default_nettype none

// Notes on behaviour
// - Three idle bytes substitute matching outgoing slots
// - Substitution only when slot mode selects idle
// - Master enable low keeps interrupt deasserted
// - Master enable high: irq from status and masks
// - Missing or misaligned frame pulse sets sync error
// - Bit five shows pattern checker found state
// - Found after 32 clean checked slots
// - Once found, each pattern error sets bit three
// - Self-test completion sets bit one
// - Finished error insertion sets bit zero
// - Reserved status bits and enable upper bits read zero
// - Status read clears all bits until new event, except bit five while found holds
// - Status ignores masks except sync error mask
// - Event masks reset to one, block interrupt
module tsi_irq_status (
    input  wire logic       core_clk,
    input  wire logic       rst_b,
    input  wire logic [7:0] host_addr,
    input  wire logic [7:0] host_wdata,
    input  wire logic       host_wr,
    input  wire logic       host_rd,
    output var  logic [7:0] host_rdata,
    input  wire logic       frame_pulse,
    input  wire logic       frame_expected,
    input  wire logic       chk_run,
    input  wire logic       chk_slot_valid,
    input  wire logic       chk_slot_error,
    input  wire logic       selftest_done,
    input  wire logic       error_insert_done,
    input  wire logic [1:0] slot_mode,
    input  wire logic [7:0] slot_data_in,
    output var  logic [7:0] slot_data_out,
    output var  logic       irq
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] idle_code_one;
    logic [7:0] idle_code_two;
    logic [7:0] idle_code_three;
    logic       irq_master_enable;
    logic [7:0] irq_event_mask;
    logic [7:0] irq_event_status;
    logic       frame_pulse_meta;
    logic       frame_pulse_sync;
    logic       pattern_found;
    logic       pattern_err_pulse;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        return a == o;
    endfunction : hit

    wire wr_idle_one   = host_wr & hit(host_addr, tsi_pkg::OFS_IDLE_ONE);
    wire wr_idle_two   = host_wr & hit(host_addr, tsi_pkg::OFS_IDLE_TWO);
    wire wr_idle_three = host_wr & hit(host_addr, tsi_pkg::OFS_IDLE_THREE);
    wire wr_master     = host_wr & hit(host_addr, tsi_pkg::OFS_MASTER_EN);
    wire wr_mask       = host_wr & hit(host_addr, tsi_pkg::OFS_EVENT_MASK);
    wire rd_status     = host_rd & hit(host_addr, tsi_pkg::OFS_STATUS);

    // ------------------------------------------------------------
    // Event sources
    // ------------------------------------------------------------
    tsi_pat_lock #(
        .LOCK_SLOTS (tsi_pkg::LOCK_SLOTS)
    ) u_pat_lock (
        .core_clk    (core_clk),
        .rst_b       (rst_b),
        .chk_run     (chk_run),
        .slot_valid  (chk_slot_valid),
        .slot_error  (chk_slot_error),
        .found       (pattern_found),
        .error_pulse (pattern_err_pulse)
    );

    // Frame pulse pin synchroniser
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            frame_pulse_meta <= 1'b0;
            frame_pulse_sync <= 1'b0;
        end else begin
            frame_pulse_meta <= frame_pulse;
            frame_pulse_sync <= frame_pulse_meta;
        end
    end

    // Sync error: pulse absent or off position, blocked by its mask
    wire fs_mask    = irq_event_mask[tsi_pkg::BIT_FRAME_SYNC_ERR];
    wire fs_missing = frame_expected & ~frame_pulse_sync;
    wire fs_misalig = frame_pulse_sync & ~frame_expected;
    wire frame_sync_error_flag =
        (fs_missing | fs_misalig) & ~fs_mask;

    // New events collected into status positions
    logic [7:0] status_set;
    always_comb begin
        status_set = 8'h00;
        status_set[tsi_pkg::BIT_FRAME_SYNC_ERR] = frame_sync_error_flag;
        status_set[tsi_pkg::BIT_PATTERN_FOUND]  = pattern_found;
        status_set[tsi_pkg::BIT_PATTERN_ERR]    = pattern_err_pulse;
        status_set[tsi_pkg::BIT_SELFTEST_DONE]  = selftest_done;
        status_set[tsi_pkg::BIT_INSERT_DONE]    = error_insert_done;
    end

    // Read clears, a coincident event wins over the clear
    wire [7:0] status_keep = rd_status ? 8'h00 : irq_event_status;
    wire [7:0] next_status =
        (status_keep | status_set) & tsi_pkg::STATUS_USED;

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            idle_code_one   <= tsi_pkg::RST_IDLE_CODE;
            idle_code_two   <= tsi_pkg::RST_IDLE_CODE;
            idle_code_three <= tsi_pkg::RST_IDLE_CODE;
        end else begin
            if (wr_idle_one) idle_code_one <= host_wdata;
            if (wr_idle_two) idle_code_two <= host_wdata;
            if (wr_idle_three) idle_code_three <= host_wdata;
        end
    end

    // Enable, mask and status
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            irq_master_enable <= 1'b0;
            irq_event_mask    <= tsi_pkg::RST_EVENT_MASK;
            irq_event_status  <= 8'h00;
        end else begin
            if (wr_master)
                irq_master_enable <= host_wdata[tsi_pkg::BIT_MASTER_EN];
            if (wr_mask) irq_event_mask <= host_wdata & tsi_pkg::MASK_WRITABLE;
            irq_event_status <= next_status;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    wire [7:0] mask_view = irq_event_mask | tsi_pkg::MASK_RSVD_ONES;
    wire [7:0] read_mux =
        hit(host_addr, tsi_pkg::OFS_IDLE_ONE)   ? idle_code_one   :
        hit(host_addr, tsi_pkg::OFS_IDLE_TWO)   ? idle_code_two   :
        hit(host_addr, tsi_pkg::OFS_IDLE_THREE) ? idle_code_three :
        hit(host_addr, tsi_pkg::OFS_MASTER_EN)  ? {7'h00, irq_master_enable} :
        hit(host_addr, tsi_pkg::OFS_STATUS)     ? irq_event_status :
        hit(host_addr, tsi_pkg::OFS_EVENT_MASK) ? mask_view : 8'h00;

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            host_rdata <= 8'h00;
        end else if (host_rd) begin
            host_rdata <= read_mux;
        end
    end

    // ------------------------------------------------------------
    // Outgoing slot data select
    // ------------------------------------------------------------
    logic [7:0] next_slot_data;
    always_comb begin
        unique case (tsi_pkg::tsi_slot_mode_t'(slot_mode))
            tsi_pkg::TSI_MODE_PASS:  next_slot_data = slot_data_in;
            tsi_pkg::TSI_MODE_IDLE1: next_slot_data = idle_code_one;
            tsi_pkg::TSI_MODE_IDLE2: next_slot_data = idle_code_two;
            tsi_pkg::TSI_MODE_IDLE3: next_slot_data = idle_code_three;
        endcase
    end

    // Interrupt level from unmasked status and master enable
    wire [7:0] unmasked = irq_event_status & ~irq_event_mask;
    wire next_irq = irq_master_enable & (|unmasked);

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            slot_data_out <= 8'h00;
            irq           <= 1'b0;
        end else begin
            slot_data_out <= next_slot_data;
            irq           <= next_irq;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    master_off_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        !$past(irq_master_enable) |-> !irq)
        else $error("irq asserted with master enable off");

    irq_level_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        irq == ($past(irq_master_enable) && |$past(unmasked)))
        else $error("irq does not follow unmasked status");

    fs_masked_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        fs_mask |=> !irq_event_status[tsi_pkg::BIT_FRAME_SYNC_ERR] ||
            $past(irq_event_status[tsi_pkg::BIT_FRAME_SYNC_ERR]))
        else $error("sync error set while masked");

    fs_missing_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (frame_expected && !frame_pulse_sync && !fs_mask)
        |=> irq_event_status[tsi_pkg::BIT_FRAME_SYNC_ERR])
        else $error("missing frame pulse not flagged");

    read_clear_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (rd_status && status_set == 8'h00)
        |=> irq_event_status == 8'h00)
        else $error("status not cleared by read");

    rsvd_zero_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (irq_event_status & ~tsi_pkg::STATUS_USED) == 8'h00)
        else $error("reserved status bit set");

    found_bit_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        pattern_found |=> irq_event_status[tsi_pkg::BIT_PATTERN_FOUND])
        else $error("found state not shown in status");

    selftest_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        selftest_done |=> irq_event_status[tsi_pkg::BIT_SELFTEST_DONE])
        else $error("self-test completion lost");

    insert_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        error_insert_done
        |=> irq_event_status[tsi_pkg::BIT_INSERT_DONE])
        else $error("error insertion completion lost");

    idle_sub_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        slot_mode == tsi_pkg::TSI_MODE_IDLE1
        |=> slot_data_out == $past(idle_code_one))
        else $error("idle code one not substituted");

    mask_reset_a: assert property (@(posedge core_clk)
        !rst_b |=> irq_event_mask == tsi_pkg::RST_EVENT_MASK)
        else $error("event mask not reset to ones");

endmodule : tsi_irq_status

`default_nettype wire

// ### dv/tsi_irq_status_bench.sv
// Self-checking bench for the idle-code and interrupt status slice
`default_nettype none

`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin \
    fail_count++; $display("unexpected t=%0t got=%h exp=%h", \
    $time, (got), (exp)); end end

module tsi_irq_status_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic       core_clk, rst_b, host_wr, host_rd, frame_pulse;
    logic       frame_expected, chk_run, chk_slot_valid, chk_slot_error;
    logic       selftest_done, error_insert_done, irq;
    logic [7:0] host_addr, host_wdata, host_rdata, slot_data_in;
    logic [7:0] slot_data_out, v;
    logic [1:0] slot_mode;
    logic [7:0] ic [1:3];
    int         fail_count, compares;

    tsi_irq_status u_tsi_irq_status (
        .core_clk          (core_clk),
        .rst_b             (rst_b),
        .host_addr         (host_addr),
        .host_wdata        (host_wdata),
        .host_wr           (host_wr),
        .host_rd           (host_rd),
        .host_rdata        (host_rdata),
        .frame_pulse       (frame_pulse),
        .frame_expected    (frame_expected),
        .chk_run           (chk_run),
        .chk_slot_valid    (chk_slot_valid),
        .chk_slot_error    (chk_slot_error),
        .selftest_done     (selftest_done),
        .error_insert_done (error_insert_done),
        .slot_mode         (slot_mode),
        .slot_data_in      (slot_data_in),
        .slot_data_out     (slot_data_out),
        .irq               (irq)
    );

    // ------------------------------------------------------------
    // Clock, helpers and closing
    // ------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host_addr  = a;
        host_wdata = d;
        host_wr    = 1'b1;
        tick(1);
        host_wr    = 1'b0;
        tick(1);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        host_addr = a;
        host_rd   = 1'b1;
        tick(1);
        host_rd   = 1'b0;
        d         = host_rdata;
        tick(1);
    endtask : rd

    // Expected outgoing byte for a slot mode
    function automatic logic [7:0] slot_exp(input logic [1:0] m,
                                            input logic [7:0] d);
        return (m == 2'd0) ? d : ic[m];
    endfunction : slot_exp

    task automatic final_report;
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report

    // Cuts a hung run short
    initial begin
        #200000;
        fail_count++;
        final_report();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {rst_b, host_wr, host_rd, frame_pulse, frame_expected} = '0;
        {chk_run, chk_slot_valid, chk_slot_error} = '0;
        {selftest_done, error_insert_done} = '0;
        {host_addr, host_wdata, slot_data_in, slot_mode} = '0;
        fail_count = 0;
        compares   = 0;
        void'($urandom(60951));
        repeat (20) @(posedge core_clk);
        #1;
        rst_b = 1'b1;
        tick(1);
        // Reset values, unmapped places and read-only bits
        for (int a = 3; a <= 10; a++) begin
            rd(a[7:0], v);
            `CHK(v, (a == 8) ? 8'h7F : 8'h00)
        end
        wr(8'h06, 8'hFF);
        rd(8'h06, v);
        `CHK(v, 8'h01)
        wr(8'h08, 8'hFF);
        rd(8'h08, v);
        `CHK(v, 8'h7F)
        // Idle codes written at random and substituted per mode
        for (int i = 1; i <= 3; i++) begin
            ic[i] = 8'($urandom);
            wr(8'(i + 2), ic[i]);
            rd(8'(i + 2), v);
            `CHK(v, ic[i])
        end
        for (int i = 0; i < 24; i++) begin
            slot_mode    = (i < 4) ? 2'(i) : 2'($urandom);
            slot_data_in = 8'($urandom);
            tick(1);
            `CHK(slot_data_out, slot_exp(slot_mode, slot_data_in))
        end
        // Masked self-test event with the master enable on
        selftest_done = 1'b1;
        tick(1);
        selftest_done = 1'b0;
        tick(3);
        `CHK(irq, 1'b0)
        rd(8'h07, v);
        `CHK(v, 8'h02)
        rd(8'h07, v);
        `CHK(v, 8'h00)
        // Unmasked insertion event drives the level until read
        wr(8'h08, 8'h7E);
        error_insert_done = 1'b1;
        tick(1);
        error_insert_done = 1'b0;
        tick(3);
        `CHK(irq, 1'b1)
        rd(8'h07, v);
        `CHK(v, 8'h01)
        tick(2);
        `CHK(irq, 1'b0)
        // Frame sync: masked, aligned, then a lone expected position
        wr(8'h06, 8'h00);
        wr(8'h08, 8'h7F);
        frame_expected = 1'b1;
        tick(1);
        frame_expected = 1'b0;
        tick(5);
        rd(8'h07, v);
        `CHK(v & 8'h40, 8'h00)
        wr(8'h08, 8'h3F);
        rd(8'h08, v);
        `CHK(v, 8'h3F)
        frame_pulse = 1'b1;
        tick(1);
        frame_pulse = 1'b0;
        tick(1);
        frame_expected = 1'b1;
        tick(1);
        frame_expected = 1'b0;
        tick(5);
        rd(8'h07, v);
        `CHK(v & 8'h40, 8'h00)
        frame_expected = 1'b1;
        tick(1);
        frame_expected = 1'b0;
        tick(4);
        `CHK(irq, 1'b0)
        wr(8'h06, 8'h01);
        tick(2);
        `CHK(irq, 1'b1)
        rd(8'h07, v);
        `CHK(v, 8'h40)
        tick(2);
        `CHK(irq, 1'b0)
        // Pattern checker: early error, 31 clean, then the 32nd
        wr(8'h08, 8'h7F);
        chk_run        = 1'b1;
        chk_slot_valid = 1'b1;
        chk_slot_error = 1'b1;
        tick(1);
        chk_slot_error = 1'b0;
        tick(31);
        chk_slot_valid = 1'b0;
        tick(3);
        rd(8'h07, v);
        `CHK(v & 8'h28, 8'h00)
        chk_slot_valid = 1'b1;
        tick(1);
        chk_slot_valid = 1'b0;
        tick(3);
        rd(8'h07, v);
        `CHK(v & 8'hA4, 8'h20)
        chk_slot_valid = 1'b1;
        chk_slot_error = 1'b1;
        tick(1);
        {chk_slot_valid, chk_slot_error} = 2'b00;
        tick(3);
        rd(8'h07, v);
        `CHK(v & 8'h08, 8'h08)
        chk_run = 1'b0;
        tick(3);
        rd(8'h07, v);
        rd(8'h07, v);
        `CHK(v, 8'h00)
        final_report();
    end

endmodule : tsi_irq_status_bench

`default_nettype wire
